// ===== hdl/dpt_cfg.svh
`ifndef DPT_CFG_SVH
`define DPT_CFG_SVH
// Register byte offsets
`define DPT_A_CLKSEL    8'h00
`define DPT_A_CTRL      8'h04
`define DPT_A_RELOAD    8'h08
`define DPT_A_COMPARE   8'h0C
`define DPT_A_READ_LO   8'h10
`define DPT_A_READ_HI   8'h14
`define DPT_A_IRQ_FLAG  8'h18
`define DPT_A_IRQ_MASK  8'h1C
`define DPT_A_STATUS    8'h20
// Per-timer stride inside the timer bank
`define DPT_A_STRIDE    8'h40
// Fields of the per-timer control word
`define DPT_F_RUN       0
`define DPT_F_PRESET    1
`define DPT_F_PWM       2
`define DPT_F_EVCNT     3
`define DPT_F_POL       4
`define DPT_F_NR        5
`define DPT_F_MOD16     6
`define DPT_F_OUTSEL    7
// Fields of the interrupt flag / mask words
`define DPT_F_UF        0
`define DPT_F_CM        1
// Reset values
`define DPT_CLKSEL_RST  4'h0
// Noise rejector tick: 2048 Hz from the slow oscillator (divide by 16)
`define DPT_NR_DIV_BIT  3
`define DPT_RESP_OKAY   2'h0
`define DPT_RESP_SLVERR 2'h2
`endif

// ===== hdl/dpt_pkg.sv
package dpt_pkg;
    typedef struct packed {
        logic       run;
        logic       pwm;
        logic [3:0] clksel;
        logic [7:0] reload;
        logic [7:0] compare;
        logic       uf_mask;
        logic       cm_mask;
    } dpt_tcfg_t;

    typedef enum logic [1:0] {
        DPT_RD_IDLE,
        DPT_RD_RESP
    } dpt_rd_state_t;
endpackage : dpt_pkg

// ===== hdl/dpt_timer_unit.sv
// Overview of operation
// - Four-bit selector picks 15 oscillator divisions or off
// - Selector resets to zero, no clock then
// - Preset bit copies reload value into counter
// - Run bit starts and stops, value kept
// - Low nibble read latches high nibble
// - Underflow reloads counter and keeps counting
// - Upper underflow exported as serial clock source
// - Event mode clocks lower timer from pin
// - Polarity zero falling edge, one rising edge
// - Noise rejector accepts change at second tick
// - PWM mode compare equality gives match pulse
// - PWM output high on underflow, low on match
// - Reload must exceed nonzero compare value
// - Cascade mode makes one 16-bit counter
// - Cascade: lower controls, upper counts lower underflows
// - Cascade: upper PWM bit, upper drives output
// - Cascade: low read freezes upper twelve bits
// - Events set flags regardless of mask
// - Compare flag only set in PWM mode
// - Cascade: underflow flag from upper timer only
// - Normal mode output toggles each underflow
//
// The register offsets and register access over AXI4-Lite were decided locally.
`include "dpt_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module dpt_timer_unit
    import dpt_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // Oscillators (clock levels; synchronised here and counted on rising edges)
    input  wire logic        low_speed_oscillator,
    input  wire logic        high_speed_oscillator,
    // Event pin
    input  wire logic        event_input,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Timer outputs
    output logic             timer_pulse_output,
    output logic             serial_clock_source,
    output logic             event_pin_input_mode,
    output logic [1:0]       underflow_irq,
    output logic [1:0]       compare_irq
);

    // Configuration per timer
    dpt_tcfg_t  cfg_q [2];
    logic       evcnt_q;
    logic       pol_q;
    logic       nr_q;
    logic       mod16_q;
    logic       outsel_q;
    logic [7:0] cnt_q [2];
    logic [1:0] uf_flag_q [2];
    logic       tog_q [2];
    logic       pwm_q [2];
    logic [11:0] hold_q;
    logic [7:0] ldiv_q;
    logic [7:0] hdiv_q;
    logic       lo_s1_q, lo_s2_q, lo_s3_q;
    logic       hi_s1_q, hi_s2_q, hi_s3_q;
    logic       ev_s1_q, ev_s2_q, ev_s3_q;
    logic       ev_lvl_q;
    logic       nr_lvl_q;
    logic [1:0] nr_cnt_q;
    logic       lo_rise, hi_rise, ev_chg;

    // Oscillators and pin pass three stages; a pin change counts when stages 2 and 3 agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {lo_s1_q, lo_s2_q, lo_s3_q} <= 3'h0;
            {hi_s1_q, hi_s2_q, hi_s3_q} <= 3'h0;
            {ev_s1_q, ev_s2_q, ev_s3_q} <= 3'h0;
        end
        else if (clk_en)
        begin
            {lo_s1_q, lo_s2_q, lo_s3_q} <= {low_speed_oscillator, lo_s1_q, lo_s2_q};
            {hi_s1_q, hi_s2_q, hi_s3_q} <= {high_speed_oscillator, hi_s1_q, hi_s2_q};
            {ev_s1_q, ev_s2_q, ev_s3_q} <= {event_input, ev_s1_q, ev_s2_q};
        end
    end

    assign lo_rise = lo_s2_q & ~lo_s3_q;
    assign hi_rise = hi_s2_q & ~hi_s3_q;

    // Free-running oscillator dividers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ldiv_q <= 8'h00;
            hdiv_q <= 8'h00;
        end
        else if (clk_en)
        begin
            if (lo_rise)
                ldiv_q <= ldiv_q + 8'h01;
            if (hi_rise)
                hdiv_q <= hdiv_q + 8'h01;
        end
    end

    // One-cycle tick when divider bit (n-1) lands on a count that is a multiple of 2^n
    function automatic logic div_tick(input logic [7:0] d, input logic r, input int unsigned n);
        logic [7:0] m;
        m = 8'((1 << n) - 1);
        div_tick = r & ((d & m) == m);
    endfunction : div_tick

    // Count clock selection, code 0 gives nothing
    function automatic logic sel_tick(input logic [3:0] s, input logic [7:0] ld, input logic [7:0] hd,
                                      input logic lr, input logic hr);
        unique case (s)
            4'h0: sel_tick = 1'b0;
            4'h1: sel_tick = div_tick(ld, lr, 8);
            4'h2: sel_tick = div_tick(ld, lr, 6);
            4'h3: sel_tick = div_tick(ld, lr, 5);
            4'h4: sel_tick = div_tick(ld, lr, 4);
            4'h5: sel_tick = div_tick(ld, lr, 2);
            4'h6: sel_tick = div_tick(ld, lr, 1);
            4'h7: sel_tick = lr;
            4'h8: sel_tick = div_tick(hd, hr, 8);
            4'h9: sel_tick = div_tick(hd, hr, 6);
            4'hA: sel_tick = div_tick(hd, hr, 5);
            4'hB: sel_tick = div_tick(hd, hr, 4);
            4'hC: sel_tick = div_tick(hd, hr, 3);
            4'hD: sel_tick = div_tick(hd, hr, 2);
            4'hE: sel_tick = div_tick(hd, hr, 1);
            4'hF: sel_tick = hr;
        endcase
    endfunction : sel_tick

    // Noise rejector: level change taken at second falling edge of 2048 Hz tick
    logic nr_fall;
    logic ev_raw;
    logic ev_src;
    assign nr_fall = div_tick(ldiv_q, lo_rise, `DPT_NR_DIV_BIT + 1);
    assign ev_raw  = (ev_s2_q == ev_s3_q) ? ev_s3_q : ev_lvl_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ev_lvl_q <= 1'b0;
            nr_lvl_q <= 1'b0;
            nr_cnt_q <= 2'h0;
        end
        else if (clk_en)
        begin
            ev_lvl_q <= ev_raw;
            // Rejector off: track the pin so enabling it makes no false edge
            if (!nr_q || ev_raw == nr_lvl_q)
            begin
                nr_lvl_q <= ev_raw;
                nr_cnt_q <= 2'h0;
            end
            else if (nr_fall && nr_cnt_q == 2'h1)
            begin
                nr_lvl_q <= ev_raw;
                nr_cnt_q <= 2'h0;
            end
            else if (nr_fall)
                nr_cnt_q <= 2'h1;
        end
    end

    logic ev_prev_q;
    assign ev_src = nr_q ? nr_lvl_q : ev_lvl_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ev_prev_q <= 1'b0;
        else if (clk_en)
            ev_prev_q <= ev_src;
    end
    // Polarity: 0 falling, 1 rising
    assign ev_chg = pol_q ? (ev_src & ~ev_prev_q) : (~ev_src & ev_prev_q);

    // Count enables per timer
    logic       tick0, tick1, dec0, dec1, uf0, uf1, cm0, cm1;
    assign tick0 = evcnt_q ? ev_chg
                           : sel_tick(cfg_q[0].clksel, ldiv_q, hdiv_q, lo_rise, hi_rise);
    assign dec0  = clk_en & cfg_q[0].run & tick0;
    assign uf0   = dec0 & (cnt_q[0] == 8'h00);
    assign tick1 = sel_tick(cfg_q[1].clksel, ldiv_q, hdiv_q, lo_rise, hi_rise);
    assign dec1  = mod16_q ? uf0 : (clk_en & cfg_q[1].run & tick1);
    assign uf1   = dec1 & (cnt_q[1] == 8'h00);
    assign cm0   = dec0 & cfg_q[0].pwm & ~mod16_q & (cnt_q[0] - 8'h01 == cfg_q[0].compare);
    assign cm1   = dec1 & cfg_q[1].pwm & (cnt_q[1] - 8'h01 == cfg_q[1].compare)
                   & (~mod16_q | (cnt_q[0] == 8'h00));

    // AXI4-Lite write channel
    logic [7:0]  aw_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        aw_have_q, w_have_q;
    logic        wr_go;
    logic        sel_t;
    logic [7:0]  wreg;
    logic        wr_ok;
    assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign sel_t = aw_q[6];
    assign wreg  = {2'h0, aw_q[5:0]};
    assign wr_ok = (aw_q[7] == 1'b0) && (wreg <= `DPT_A_STATUS);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_q          <= 8'h00;
            wd_q          <= 32'h0;
            ws_q          <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DPT_RESP_OKAY;
        end
        else if (clk_en)
        begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wd_q     <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `DPT_RESP_OKAY : `DPT_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_clksel, wr_ctrl, wr_reload, wr_cmp, wr_flag, wr_mask;
    assign wr_clksel = wr_go & wr_ok & ws_q[0] & (wreg == `DPT_A_CLKSEL);
    assign wr_ctrl   = wr_go & wr_ok & ws_q[0] & (wreg == `DPT_A_CTRL);
    assign wr_reload = wr_go & wr_ok & ws_q[0] & (wreg == `DPT_A_RELOAD);
    assign wr_cmp    = wr_go & wr_ok & ws_q[0] & (wreg == `DPT_A_COMPARE);
    assign wr_flag   = wr_go & wr_ok & ws_q[0] & (wreg == `DPT_A_IRQ_FLAG);
    assign wr_mask   = wr_go & wr_ok & ws_q[0] & (wreg == `DPT_A_IRQ_MASK);

    // Timer state
    logic [1:0] set_uf, set_cm;
    assign set_uf = {uf1, uf0 & ~mod16_q};
    assign set_cm = {cm1, cm0};
    for (genvar t = 0; t < 2; t++)
    begin : g_tmr
        logic me, dec, uf, cm, pst;
        assign me  = (sel_t == 1'(t));
        assign dec = (t == 0) ? dec0 : dec1;
        assign uf  = (t == 0) ? uf0 : uf1;
        assign cm  = (t == 0) ? cm0 : cm1;
        assign pst = wr_ctrl & me & wd_q[`DPT_F_PRESET];
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                cfg_q[t]     <= '{default: '0};
                cfg_q[t].clksel <= `DPT_CLKSEL_RST;
                cnt_q[t]     <= 8'h00;
                uf_flag_q[t] <= 2'h0;
                tog_q[t]     <= 1'b0;
                pwm_q[t]     <= 1'b0;
            end
            else if (clk_en)
            begin
                if (wr_clksel && me)
                    cfg_q[t].clksel <= wd_q[3:0];
                if (wr_ctrl && me)
                begin
                    cfg_q[t].run <= wd_q[`DPT_F_RUN];
                    cfg_q[t].pwm <= wd_q[`DPT_F_PWM];
                end
                if (wr_reload && me)
                    cfg_q[t].reload <= wd_q[7:0];
                if (wr_cmp && me)
                    cfg_q[t].compare <= wd_q[7:0];
                if (wr_mask && me)
                    {cfg_q[t].cm_mask, cfg_q[t].uf_mask} <= wd_q[1:0];
                if (pst)
                    cnt_q[t] <= cfg_q[t].reload;
                else if (uf)
                    cnt_q[t] <= cfg_q[t].reload;
                else if (dec)
                    cnt_q[t] <= cnt_q[t] - 8'h01;
                // Set wins over a write-one clear
                uf_flag_q[t][`DPT_F_UF] <= set_uf[t]
                    | (uf_flag_q[t][`DPT_F_UF] & ~(wr_flag & me & wd_q[`DPT_F_UF]));
                uf_flag_q[t][`DPT_F_CM] <= set_cm[t]
                    | (uf_flag_q[t][`DPT_F_CM] & ~(wr_flag & me & wd_q[`DPT_F_CM]));
                if (uf)
                    tog_q[t] <= ~tog_q[t];
                if (uf)
                    pwm_q[t] <= 1'b1;
                else if (cm)
                    pwm_q[t] <= 1'b0;
            end
        end
    end

    // Unit-wide control bits live in timer 0's control word
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {outsel_q, mod16_q, nr_q, pol_q, evcnt_q} <= 5'h00;
        else if (clk_en && wr_ctrl && !sel_t)
            {outsel_q, mod16_q, nr_q, pol_q, evcnt_q} <= wd_q[`DPT_F_OUTSEL:`DPT_F_EVCNT];
    end

    // AXI4-Lite read channel
    dpt_rd_state_t rd_st_q;
    logic [7:0]    rreg;
    logic          rsel;
    logic          lo_read;
    logic [31:0]   rmux;
    logic          rd_ok;
    assign rsel    = s_axi_araddr[6];
    assign rreg    = {2'h0, s_axi_araddr[5:0]};
    assign rd_ok   = (s_axi_araddr[7] == 1'b0) && (rreg <= `DPT_A_STATUS);
    assign lo_read = s_axi_arvalid & s_axi_arready & rd_ok & (rreg == `DPT_A_READ_LO) & ~rsel;

    always_comb
    begin
        rmux = 32'h0;
        unique case (rreg)
            `DPT_A_CLKSEL:   rmux = {28'h0, cfg_q[rsel].clksel};
            `DPT_A_CTRL:     rmux = {24'h0, rsel ? 5'h00 : {outsel_q, mod16_q, nr_q, pol_q, evcnt_q},
                                     cfg_q[rsel].pwm, 1'b0, cfg_q[rsel].run};
            `DPT_A_RELOAD:   rmux = {24'h0, cfg_q[rsel].reload};
            `DPT_A_COMPARE:  rmux = {24'h0, cfg_q[rsel].compare};
            `DPT_A_READ_LO:  rmux = {28'h0, cnt_q[0][3:0]};
            `DPT_A_READ_HI:  rmux = {20'h0, hold_q};
            `DPT_A_IRQ_FLAG: rmux = {30'h0, uf_flag_q[rsel]};
            `DPT_A_IRQ_MASK: rmux = {30'h0, cfg_q[rsel].cm_mask, cfg_q[rsel].uf_mask};
            `DPT_A_STATUS:   rmux = {16'h0, cnt_q[1], cnt_q[0]};
            default:         rmux = 32'h0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_st_q       <= DPT_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `DPT_RESP_OKAY;
            hold_q        <= 12'h000;
        end
        else if (clk_en)
        begin
            unique case (rd_st_q)
                DPT_RD_IDLE:
                begin
                    s_axi_arready <= s_axi_arvalid & ~s_axi_arready;
                    if (s_axi_arvalid && s_axi_arready)
                    begin
                        s_axi_rdata   <= rmux;
                        s_axi_rresp   <= rd_ok ? `DPT_RESP_OKAY : `DPT_RESP_SLVERR;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_arready <= 1'b0;
                        rd_st_q       <= DPT_RD_RESP;
                    end
                end
                DPT_RD_RESP:
                begin
                    if (s_axi_rready)
                    begin
                        s_axi_rvalid <= 1'b0;
                        rd_st_q      <= DPT_RD_IDLE;
                    end
                end
            endcase
            // Low read freezes the rest; 8-bit mode holds only the upper nibble
            if (lo_read)
                hold_q <= mod16_q ? {cnt_q[1], cnt_q[0][7:4]} : {4'h0, 4'h0, cnt_q[0][7:4]};
        end
    end

    // Outputs
    logic tout_d;
    assign tout_d = (mod16_q | outsel_q) ? (cfg_q[1].pwm ? pwm_q[1] : tog_q[1])
                                         : (cfg_q[0].pwm ? pwm_q[0] : tog_q[0]);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_pulse_output   <= 1'b0;
            serial_clock_source  <= 1'b0;
            event_pin_input_mode <= 1'b0;
            underflow_irq        <= 2'h0;
            compare_irq          <= 2'h0;
        end
        else if (clk_en)
        begin
            timer_pulse_output   <= tout_d;
            serial_clock_source  <= uf1;
            event_pin_input_mode <= evcnt_q;
            underflow_irq <= {uf_flag_q[1][0] & cfg_q[1].uf_mask, uf_flag_q[0][0] & cfg_q[0].uf_mask};
            compare_irq   <= {uf_flag_q[1][1] & cfg_q[1].cm_mask, uf_flag_q[0][1] & cfg_q[0].cm_mask};
        end
    end

    // Checks
    chk_uf_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && uf0 && !(wr_ctrl && !sel_t && wd_q[1])) |=> (cnt_q[0] == $past(cfg_q[0].reload)))
        else $error("underflow did not reload");
    chk_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (!cfg_q[0].run && !mod16_q && !wr_ctrl) |=> $stable(cnt_q[0]))
        else $error("stopped counter changed");
    chk_clk_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg_q[1].clksel == 4'h0 && !mod16_q) |-> !dec1)
        else $error("timer counted with clock off");
    chk_cm_pwm: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && !cfg_q[0].pwm) |=> !uf_flag_q[0][1] || $past(uf_flag_q[0][1]))
        else $error("compare flag set outside pwm");
    chk_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && uf1) |=> uf_flag_q[1][0])
        else $error("underflow flag missed");
    chk_cascade_uf: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && mod16_q && uf0 && !(wr_flag && !sel_t)) |=> (uf_flag_q[0][0] == $past(uf_flag_q[0][0])))
        else $error("lower flag set in cascade");
    sequence s_lo_read;
        lo_read && clk_en;
    endsequence
    chk_hold_low: assert property (@(posedge aclk) disable iff (!aresetn)
        s_lo_read |=> (hold_q[3:0] == $past(cnt_q[0][7:4])))
        else $error("high nibble not latched");
    chk_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && uf0) |=> (tog_q[0] != $past(tog_q[0])))
        else $error("output did not toggle");
    chk_serial_clk: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && uf1) |=> serial_clock_source)
        else $error("serial clock pulse missing");

endmodule : dpt_timer_unit

`default_nettype wire

// ===== tb/dpt_event_source.sv
`timescale 1ns/10ps
`default_nettype none

module dpt_event_source
(
    // Clock
    input  wire logic aclk,
    // Event pin, idle high
    output var logic  event_input
);
    initial event_input = 1'b1;

    // Low then high, each level held for hold cycles
    task automatic pulse(input int hold, input int n);
        repeat (n)
        begin
            @(posedge aclk);
            event_input <= 1'b0;
            repeat (hold) @(posedge aclk);
            event_input <= 1'b1;
            repeat (hold) @(posedge aclk);
        end
    endtask : pulse
endmodule : dpt_event_source

`default_nettype wire

// ===== tb/testbench.sv
`include "dpt_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, event_input, tpo, scs, evmode;
    logic [7:0]  osc_q, awaddr, araddr;
    logic [31:0] wdata, rdata, v, v1;
    logic [1:0]  bresp, rresp, resp_v, uf_irq, cm_irq;
    int          failures, checks, hi_n, tog_n, scs_n;

    dpt_timer_unit dut
    (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .low_speed_oscillator(osc_q[6]), .high_speed_oscillator(osc_q[2]), .event_input(event_input),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_pulse_output(tpo), .serial_clock_source(scs),
        .event_pin_input_mode(evmode), .underflow_irq(uf_irq), .compare_irq(cm_irq)
    );

    dpt_event_source src (.aclk(aclk), .event_input(event_input));

    always #5 aclk = ~aclk;

    always @(posedge aclk)
    begin
        osc_q <= osc_q + 8'h01;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (!bvalid) failures++;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (!rvalid) failures++;
        v = rdata;
        resp_v = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(v, exp);
    endtask : rdc

    // Counts output high cycles, output toggles and serial clock pulses
    task automatic watch(input int cyc);
        logic last;
        hi_n = 0;
        tog_n = 0;
        scs_n = 0;
        last = tpo;
        repeat (cyc)
        begin
            @(posedge aclk);
            hi_n += int'(tpo);
            tog_n += int'(tpo != last);
            scs_n += int'(scs);
            last = tpo;
        end
    endtask : watch

    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (50000) @(posedge aclk);
        failures++;
        end_sim();
    end

    initial
    begin
        {aclk, osc_q, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        aresetn = 1'b0;
        clk_en = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(`DPT_A_CLKSEL, 32'h0);
        rdc(`DPT_A_STRIDE + `DPT_A_CLKSEL, 32'h0);
        wr(`DPT_A_RELOAD, 32'h80);
        wr(`DPT_A_CTRL, 32'h3);
        repeat (100) @(posedge aclk);
        rdc(`DPT_A_STATUS, 32'h80);
        wr(`DPT_A_CLKSEL, 32'hF);
        repeat (200) @(posedge aclk);
        wr(`DPT_A_CTRL, 32'h0);
        rd(`DPT_A_STATUS);
        v1 = v;
        check(v1 < 32'h80 && v1 > 32'h50, 1'b1);
        repeat (100) @(posedge aclk);
        rdc(`DPT_A_STATUS, v1);
        rdc(`DPT_A_READ_LO, {28'h0, v1[3:0]});
        rdc(`DPT_A_READ_HI, {28'h0, v1[7:4]});
        wr(`DPT_A_CTRL, 32'h1);
        rd(`DPT_A_READ_LO);
        rd(`DPT_A_READ_HI);
        v1 = v;
        repeat (200) @(posedge aclk);
        rdc(`DPT_A_READ_HI, v1);
        $display("test basic count done");
        wr(`DPT_A_RELOAD, 32'h3);
        wr(`DPT_A_CTRL, 32'h3);
        watch(320);
        check(tog_n >= 9 && tog_n <= 11, 1'b1);
        rd(`DPT_A_STATUS);
        check(v[7:0] <= 8'h3, 1'b1);
        rdc(`DPT_A_IRQ_FLAG, 32'h1);
        check(uf_irq, 2'b00);
        wr(`DPT_A_IRQ_MASK, 32'h1);
        repeat (4) @(posedge aclk);
        check(uf_irq, 2'b01);
        wr(`DPT_A_CTRL, 32'h0);
        wr(`DPT_A_IRQ_FLAG, 32'h0);
        rdc(`DPT_A_IRQ_FLAG, 32'h1);
        wr(`DPT_A_IRQ_FLAG, 32'h1);
        rdc(`DPT_A_IRQ_FLAG, 32'h0);
        check(uf_irq, 2'b00);
        wr(8'h48, 32'h1);
        wr(8'h40, 32'hE);
        wr(8'h44, 32'h3);
        watch(320);
        check(scs_n >= 9 && scs_n <= 11, 1'b1);
        wr(8'h44, 32'h0);
        $display("test underflow done");
        wr(`DPT_A_RELOAD, 32'hA);
        wr(`DPT_A_COMPARE, 32'h4);
        wr(`DPT_A_CTRL, 32'h7);
        repeat (100) @(posedge aclk);
        watch(880);
        check(hi_n >= 440 && hi_n <= 520, 1'b1);
        rdc(`DPT_A_IRQ_FLAG, 32'h3);
        wr(`DPT_A_IRQ_MASK, 32'h2);
        check(cm_irq, 2'b01);
        wr(`DPT_A_COMPARE, 32'hC);
        repeat (100) @(posedge aclk);
        watch(200);
        check(hi_n, 200);
        wr(`DPT_A_CTRL, 32'h0);
        $display("test pwm done");
        wr(`DPT_A_RELOAD, 32'hFF);
        wr(`DPT_A_CTRL, 32'hB);
        check(evmode, 1'b1);
        src.pulse(10, 5);
        repeat (10) @(posedge aclk);
        rd(`DPT_A_STATUS);
        check(v[7:0], 8'hFA);
        wr(`DPT_A_CTRL, 32'h1B);
        src.pulse(10, 3);
        repeat (10) @(posedge aclk);
        rd(`DPT_A_STATUS);
        check(v[7:0], 8'hFC);
        wr(`DPT_A_CTRL, 32'h3B);
        src.pulse(20, 1);
        src.pulse(5000, 1);
        rd(`DPT_A_STATUS);
        check(v[7:0], 8'hFE);
        wr(`DPT_A_CTRL, 32'h0);
        $display("test event count done");
        wr(`DPT_A_IRQ_FLAG, 32'h3);
        wr(8'h48, 32'h1);
        wr(8'h44, 32'h2);
        wr(8'h58, 32'h3);
        wr(8'h40, 32'h0);
        wr(`DPT_A_RELOAD, 32'h2);
        wr(`DPT_A_CTRL, 32'h43);
        watch(480);
        check(tog_n >= 9 && tog_n <= 11, 1'b1);
        check(scs_n >= 9 && scs_n <= 11, 1'b1);
        clk_en <= 1'b0;
        @(posedge aclk);
        watch(100);
        check(tog_n, 0);
        clk_en <= 1'b1;
        rdc(`DPT_A_IRQ_FLAG, 32'h0);
        rd(8'h58);
        check(v[0], 1'b1);
        wr(`DPT_A_CTRL, 32'h40);
        rd(`DPT_A_STATUS);
        v1 = v;
        rdc(`DPT_A_READ_LO, {28'h0, v1[3:0]});
        rdc(`DPT_A_READ_HI, {20'h0, v1[15:4]});
        $display("test cascade done");
        rd(8'h30);
        check(resp_v, `DPT_RESP_SLVERR);
        $display("test unmapped done");
        end_sim();
    end
endmodule : testbench

`default_nettype wire
